// file: core/config_register_bank.sv
// Configuration register bank with key entry, device selection and four reset sources.
`timescale 1ns/1ps
module config_register_bank
	import cfg_bank_pkg::*;
#(
	parameter int BLOCK_COUNT = cfg_bank_pkg::BLOCK_CYCLES, // Lockout length; shorten in sim.
	parameter logic [7:0] IDENTITY_VALUE = 8'h5A, // Arbitrary identity value.
	parameter logic [7:0] REVISION_VALUE = 8'h01 // Arbitrary revision value.
) (
	input wire logic clk_in,
	input wire logic rst_in, // Host bus reset input, a hard reset.
	input wire logic main_por_in, // Main-supply power-on reset, synchronous.
	input wire logic standby_por_in, // Standby-supply power-on reset, synchronous.
	input wire logic strap_in, // Address strap pin, asynchronous.
	cfg_bus_if.bank bus,
	output logic config_mode_out, // High while in configuration mode.
	output logic host_blocked_out, // High during the power-on lockout.
	output logic [7:0] floppy_activate_out // Floppy activate register.
);
	import cfg_bank_pkg::*;

	// Run and configuration states of the key protocol.
	typedef enum {RUN, CONFIG} mode_e;
	mode_e mode_q;
	logic strap_meta_q; // First stage; only the second stage reads it.
	logic strap_q; // Synchronised strap level.
	logic [15:0] port_q; // Current configuration port address.
	logic [7:0] index_q; // Latched index.
	logic [7:0] ldn_q; // Selected logical device.
	logic [7:0] regs_q [0:255]; // Global plus the device sets, see the slot function.
	logic [$clog2(BLOCK_COUNT + 1)-1:0] block_q; // Lockout counter, sized by the parameter.
	logic any_hard; // Hard or main-supply power-on.
	logic any_reset; // Any of the three pin-driven resets.
	logic soft_reset; // Soft reset request from a control write.
	logic hit_index; // Cycle at the index/config port.
	logic hit_data; // Cycle at the data port.
	logic [7:0] slot; // Storage slot of the addressed register.
	logic slot_ok; // The addressed register exists.

	// Maps device and index onto one compact slot of storage; 8'hFF means none.
	function automatic logic [7:0] slot_of(input logic [7:0] ldn, input logic [7:0] idx);
		logic [7:0] base;
		base = 8'h00;
		if (idx < IDX_FIRST_LOCAL) begin
			return idx; // Global registers sit at their own index.
		end
		case (ldn)
			LDN_FLOPPY: base = 8'h40;
			LDN_PARPORT: base = 8'h60;
			LDN_SERIAL1: base = 8'h80;
			LDN_SERIAL2: base = 8'hA0;
			default: return 8'hFF;
		endcase
		case (idx)
			IDX_ACTIVATE: return base;
			IDX_BASE_HIGH: return base + 8'h01;
			IDX_BASE_LOW: return base + 8'h02;
			IDX_IRQ: return base + 8'h03;
			IDX_MODE: return base + 8'h04;
			IDX_DMA: return (ldn == LDN_FLOPPY || ldn == LDN_PARPORT) ? base + 8'h05 : 8'hFF;
			IDX_MODE_TWO: return (ldn == LDN_SERIAL1) ? 8'hFF : base + 8'h06;
			IDX_TYPE: return (ldn == LDN_FLOPPY || ldn == LDN_SERIAL2) ? base + 8'h07 : 8'hFF;
			IDX_DRIVE_ZERO: return (ldn == LDN_FLOPPY) ? base + 8'h08 : 8'hFF;
			IDX_DRIVE_ONE: return (ldn == LDN_FLOPPY) ? base + 8'h09 : 8'hFF;
			IDX_SPARE_HIGH: return (ldn == LDN_SERIAL2) ? base + 8'h08 : 8'hFF;
			IDX_SPARE_LOW: return (ldn == LDN_SERIAL2) ? base + 8'h09 : 8'hFF;
			default: return 8'hFF;
		endcase
	endfunction : slot_of

	// Tells whether a global index is a writable stored register.
	function automatic logic global_ok(input logic [7:0] idx);
		return idx == IDX_INDEX_ADDRESS || idx == IDX_POWER_CONTROL || idx == IDX_POWER_MGMT ||
			idx == IDX_OSC || idx == IDX_PORT_LOW || idx == IDX_PORT_HIGH ||
			(idx >= IDX_TEST_FIRST && idx <= IDX_TEST_LAST);
	endfunction : global_ok

	// Reset value of a slot; soft tells whether the slot is loaded by soft reset.
	function automatic logic [8:0] reset_of(input logic [7:0] s, input logic strap);
		case (s)
			IDX_INDEX_ADDRESS: return {1'b0, RST_INDEX_ADDRESS};
			IDX_POWER_CONTROL: return {1'b1, RST_ZERO};
			IDX_OSC: return {1'b0, RST_OSC};
			IDX_PORT_LOW: return {1'b0, strap ? RST_PORT_LOW_STRAP1 : RST_PORT_LOW_STRAP0};
			IDX_PORT_HIGH: return {1'b0, RST_PORT_HIGH};
			8'h41: return {1'b1, RST_FLOPPY_BASE_HIGH};
			8'h42: return {1'b1, RST_FLOPPY_BASE_LOW};
			8'h43: return {1'b1, RST_FLOPPY_IRQ};
			8'h45: return {1'b1, RST_FLOPPY_DMA};
			8'h44: return {1'b0, RST_FLOPPY_MODE};
			8'h47: return {1'b0, RST_FLOPPY_TYPE};
			8'h64: return {1'b0, RST_PARPORT_MODE};
			8'h65: return {1'b1, RST_PARPORT_DMA};
			8'hA6: return {1'b0, RST_IR_OPTIONS};
			8'hA7: return {1'b0, RST_IR_TIMEOUT};
			default: begin
				// Activate, base, interrupt and spare slots follow soft reset.
				if (s >= 8'h40 && s[4:0] <= 5'h03) begin
					return {1'b1, RST_ZERO};
				end
				if (s == 8'hA8 || s == 8'hA9) begin
					return {1'b1, RST_ZERO};
				end
				return {1'b0, RST_ZERO};
			end
		endcase
	endfunction : reset_of

	assign any_hard = rst_in || main_por_in;
	assign any_reset = any_hard || standby_por_in;
	assign hit_index = (bus.addr == port_q) && (block_q == '0);
	assign hit_data = (bus.addr == port_q + 16'h0001) && (block_q == '0) && (mode_q == CONFIG);
	assign slot = slot_of(ldn_q, index_q);
	assign slot_ok = (index_q < IDX_FIRST_LOCAL) ? global_ok(index_q) : (slot != 8'hFF);
	assign soft_reset = hit_data && bus.wr && index_q == IDX_CONFIG_CONTROL &&
		bus.wdata[SOFT_RESET_BIT];

	// Strap synchroniser; it samples the level on every edge, and a hard reset loads the port from it.
	always_ff @(posedge clk_in) begin
		strap_meta_q <= strap_in;
		strap_q <= strap_meta_q;
	end

	// Lockout counter after main-supply power-on; a bus reset leaves it alone.
	always_ff @(posedge clk_in) begin
		if (main_por_in) begin
			block_q <= ($bits(block_q))'(BLOCK_COUNT);
		end else if (block_q != '0) begin
			block_q <= block_q - 1'b1;
		end
	end

	// Run/configuration mode; the keys only count at the configuration port address.
	always_ff @(posedge clk_in) begin
		if (any_reset) begin
			mode_q <= RUN;
		end else if (hit_index && bus.wr && mode_q == RUN && bus.wdata == KEY_ENTER) begin
			mode_q <= CONFIG;
		end else if (hit_index && bus.wr && mode_q == CONFIG && bus.wdata == KEY_EXIT) begin
			mode_q <= RUN;
		end
	end

	// Index latch, written through the index port in configuration mode only.
	always_ff @(posedge clk_in) begin
		if (any_reset) begin
			index_q <= RST_ZERO;
		end else if (hit_index && bus.wr && mode_q == CONFIG && bus.wdata != KEY_EXIT) begin
			index_q <= bus.wdata;
		end
	end

	// Logical device selection; every reset, soft ones too, clears it.
	always_ff @(posedge clk_in) begin
		if (any_reset || soft_reset) begin
			ldn_q <= RST_ZERO;
		end else if (hit_data && bus.wr && index_q == IDX_LDN) begin
			ldn_q <= bus.wdata;
		end
	end

	// Stored registers; soft reset touches only slots marked for it.
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < 256; i++) begin
			logic [8:0] rv;
			rv = reset_of(8'(i), strap_q);
			if (any_hard) begin
				// Test registers have no bus-reset value, so only power-on clears them.
				if (main_por_in || i < IDX_TEST_FIRST || i > IDX_TEST_LAST) begin
					regs_q[i] <= rv[7:0];
				end
			end else if (standby_por_in) begin
				if (i != IDX_PORT_LOW && i != IDX_PORT_HIGH) begin
					regs_q[i] <= rv[7:0];
				end
			end else if (soft_reset) begin
				if (rv[8]) begin
					regs_q[i] <= rv[7:0];
				end
			end else if (hit_data && bus.wr && slot_ok && 8'(i) == slot) begin
				regs_q[i] <= bus.wdata;
			end
		end
	end

	// Configuration port address follows the two address registers.
	always_ff @(posedge clk_in) begin
		port_q <= {regs_q[IDX_PORT_HIGH], regs_q[IDX_PORT_LOW]};
	end

	// Read path: one cycle after the strobe the data and its valid pulse appear.
	always_ff @(posedge clk_in) begin
		if (any_reset) begin
			bus.rdata <= RST_ZERO;
			bus.rvalid <= 1'b0;
		end else begin
			bus.rvalid <= bus.rd && (hit_data || (hit_index && mode_q == CONFIG));
			if (!bus.rd) begin
				bus.rdata <= bus.rdata; // Holds the last answer until the next read.
			end else if (hit_index && mode_q == CONFIG) begin
				bus.rdata <= index_q;
			end else if (index_q == IDX_IDENTITY) begin
				bus.rdata <= IDENTITY_VALUE;
			end else if (index_q == IDX_REVISION) begin
				bus.rdata <= REVISION_VALUE;
			end else if (index_q == IDX_LDN) begin
				bus.rdata <= ldn_q;
			end else begin
				bus.rdata <= slot_ok ? regs_q[slot] : RST_ZERO;
			end
		end
	end

	// Status outputs from flip-flops.
	always_ff @(posedge clk_in) begin
		config_mode_out <= (mode_q == CONFIG) && !any_reset;
		host_blocked_out <= main_por_in || (block_q > 1);
		floppy_activate_out <= regs_q[8'h40];
	end
endmodule : config_register_bank

// file: core/cfg_bank_pkg.sv
// Package with the constants shared by the configuration bank and its host end.
package cfg_bank_pkg;
	localparam logic [15:0] CFG_PORT_DEFAULT = 16'h03F0; // Config port when the strap is low.
	localparam logic [7:0] KEY_ENTER = 8'h55; // Key that enters configuration mode.
	localparam logic [7:0] KEY_EXIT = 8'hAA; // Key that returns to the run state.
	localparam logic [7:0] IDX_CONFIG_CONTROL = 8'h02;
	localparam logic [7:0] IDX_INDEX_ADDRESS = 8'h03;
	localparam logic [7:0] IDX_LDN = 8'h07;
	localparam logic [7:0] IDX_IDENTITY = 8'h20;
	localparam logic [7:0] IDX_REVISION = 8'h21;
	localparam logic [7:0] IDX_POWER_CONTROL = 8'h22;
	localparam logic [7:0] IDX_POWER_MGMT = 8'h23;
	localparam logic [7:0] IDX_OSC = 8'h24;
	localparam logic [7:0] IDX_PORT_LOW = 8'h26;
	localparam logic [7:0] IDX_PORT_HIGH = 8'h27;
	localparam logic [7:0] IDX_TEST_FIRST = 8'h2B; // Test registers occupy 0x2B to 0x2F.
	localparam logic [7:0] IDX_TEST_LAST = 8'h2F;
	localparam logic [7:0] IDX_FIRST_LOCAL = 8'h30; // Indexes from here follow the selection.
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
	localparam logic [7:0] IDX_BASE_LOW = 8'h61;
	localparam logic [7:0] IDX_SPARE_HIGH = 8'h62;
	localparam logic [7:0] IDX_SPARE_LOW = 8'h63;
	localparam logic [7:0] IDX_IRQ = 8'h70;
	localparam logic [7:0] IDX_DMA = 8'h74;
	localparam logic [7:0] IDX_MODE = 8'hF0;
	localparam logic [7:0] IDX_MODE_TWO = 8'hF1;
	localparam logic [7:0] IDX_TYPE = 8'hF2;
	localparam logic [7:0] IDX_DRIVE_ZERO = 8'hF4;
	localparam logic [7:0] IDX_DRIVE_ONE = 8'hF5;
	localparam logic [7:0] LDN_FLOPPY = 8'h00;
	localparam logic [7:0] LDN_PARPORT = 8'h03;
	localparam logic [7:0] LDN_SERIAL1 = 8'h04;
	localparam logic [7:0] LDN_SERIAL2 = 8'h05;
	localparam int SOFT_RESET_BIT = 0; // Bit of config_control that fires a soft reset.
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_INDEX_ADDRESS = 8'h03;
	localparam logic [7:0] RST_OSC = 8'h04;
	localparam logic [7:0] RST_PORT_LOW_STRAP0 = 8'hF0;
	localparam logic [7:0] RST_PORT_LOW_STRAP1 = 8'h70;
	localparam logic [7:0] RST_PORT_HIGH = 8'h03;
	localparam logic [7:0] RST_FLOPPY_BASE_HIGH = 8'h03;
	localparam logic [7:0] RST_FLOPPY_BASE_LOW = 8'hF0;
	localparam logic [7:0] RST_FLOPPY_IRQ = 8'h06;
	localparam logic [7:0] RST_FLOPPY_DMA = 8'h02;
	localparam logic [7:0] RST_FLOPPY_MODE = 8'h0E;
	localparam logic [7:0] RST_FLOPPY_TYPE = 8'hFF;
	localparam logic [7:0] RST_PARPORT_DMA = 8'h04;
	localparam logic [7:0] RST_PARPORT_MODE = 8'h3C;
	localparam logic [7:0] RST_IR_OPTIONS = 8'h02;
	localparam logic [7:0] RST_IR_TIMEOUT = 8'h03;
	localparam int CLK_MHZ = 40; // Clock rate in MHz.
	localparam int BLOCK_TIME_US = 500; // Host lockout after main-supply power-on.
	localparam int BLOCK_CYCLES = BLOCK_TIME_US * CLK_MHZ; // 20000 cycles at 40 MHz.
endpackage : cfg_bank_pkg

// file: core/cfg_bus_if.sv
// Interface carrying the host I/O cycles between the host end and the bank.
`timescale 1ns/1ps
interface cfg_bus_if;
	logic [15:0] addr; // I/O address of the cycle.
	logic [7:0] wdata; // Write data.
	logic wr; // One-cycle write strobe.
	logic rd; // One-cycle read strobe.
	logic [7:0] rdata; // Read data from the bank.
	logic rvalid; // Pulses one cycle after a read that the bank answered.
	modport bank (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
	modport host (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
endinterface : cfg_bus_if

// file: core/config_host_end.sv
// Host end that turns user read and write requests into configuration I/O cycles.
`timescale 1ns/1ps
module config_host_end
	import cfg_bank_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic blocked_in, // Bank lockout flag, same clock.
	input wire logic req_in, // One-cycle request pulse.
	input wire logic req_write_in, // High for a write.
	input wire logic req_data_port_in, // High targets data port, low the config port.
	input wire logic [7:0] req_data_in, // Write byte.
	output logic busy_out, // High while a cycle is in flight.
	output logic done_out, // One-cycle completion pulse.
	output logic [7:0] rd_data_out, // Byte read back.
	cfg_bus_if.host bus
);
	import cfg_bank_pkg::*;

	typedef enum {IDLE, WAIT} state_e;
	state_e state_q;

	// One cycle on the bus, then wait one cycle for the read answer.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= IDLE;
			bus.addr <= CFG_PORT_DEFAULT;
			bus.wdata <= 8'h00;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
			rd_data_out <= 8'h00;
		end else begin
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			done_out <= 1'b0;
			case (state_q)
				IDLE: begin
					// Requests during the lockout are dropped, not issued.
					if (req_in && !blocked_in) begin
						bus.addr <= CFG_PORT_DEFAULT + {15'h0000, req_data_port_in};
						bus.wdata <= req_data_in;
						bus.wr <= req_write_in;
						bus.rd <= !req_write_in;
						busy_out <= 1'b1;
						state_q <= WAIT;
					end
				end
				WAIT: begin
					if (!bus.rd && !bus.wr) begin
						rd_data_out <= bus.rvalid ? bus.rdata : 8'h00;
						done_out <= 1'b1;
						busy_out <= 1'b0;
						state_q <= IDLE;
					end
				end
				default: state_q <= IDLE;
			endcase
		end
	end
endmodule : config_host_end

// file: tb/config_register_bank_monitor.sv
// Checker for the configuration bus and mode flags between the host end and the bank.
`timescale 1ns/1ps
module config_register_bank_monitor
	import cfg_bank_pkg::*;
#(
	parameter int BLOCK_COUNT = BLOCK_CYCLES // Lockout length, handed on by the bench.
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic main_por_in,
	input wire logic strap_in, // Strap level; a high strap moves the configuration port.
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic rvalid,
	input wire logic config_mode_out,
	input wire logic host_blocked_out
);
	logic [15:0] blk_cnt_q; // Lockout cycles counted since the power-on reset fell.

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in || main_por_in);

	// Counts lockout cycles; cleared under power-on reset so only the lockout tail is measured.
	always_ff @(posedge clk_in) begin
		if (main_por_in) begin
			blk_cnt_q <= 16'h0000;
		end else if (host_blocked_out) begin
			blk_cnt_q <= blk_cnt_q + 16'h0001;
		end
	end

	// A key byte written to the strap-selected config port outside the lockout.
	sequence key_wr(logic [7:0] k);
		wr && addr == {RST_PORT_HIGH, strap_in ? RST_PORT_LOW_STRAP1 : RST_PORT_LOW_STRAP0} &&
			wdata == k && !host_blocked_out;
	endsequence

	// A data-port read that the bank should answer.
	sequence data_rd;
		rd && addr == CFG_PORT_DEFAULT + 16'h0001 && config_mode_out && !host_blocked_out;
	endsequence

	// The mode flag is registered from the mode state, so it shows two edges after the write.
	enter_key_a: assert property (!config_mode_out ##0 key_wr(KEY_ENTER) |=> ##1 config_mode_out)
		else $error("entry key did not open configuration mode");
	exit_key_a: assert property (config_mode_out ##0 key_wr(KEY_EXIT) |=> ##1 !config_mode_out)
		else $error("exit key did not leave configuration mode");
	read_answer_a: assert property (data_rd |=> rvalid)
		else $error("data port read not answered");
	run_refused_a: assert property (rd && !config_mode_out |=> !rvalid)
		else $error("read answered in run state");
	lock_refused_a: assert property (rd && host_blocked_out |=> !rvalid)
		else $error("read answered during lockout");
	rvalid_cause_a: assert property (rvalid |-> $past(rd))
		else $error("read valid without a read");
	lock_start_a: assert property ($fell(main_por_in) |=> host_blocked_out [*8])
		else $error("lockout too short after power-on");
	lock_max_a: assert property (host_blocked_out |-> blk_cnt_q <= BLOCK_COUNT + 2)
		else $error("lockout runs too long");
	lock_min_a: assert property ($fell(host_blocked_out) |-> blk_cnt_q >= BLOCK_COUNT - 2)
		else $error("lockout ended early");
	reset_run_a: assert property ($fell(rst_in) |-> !config_mode_out)
		else $error("hard reset left configuration mode on");
endmodule : config_register_bank_monitor

// file: tb/config_register_bank_bench.sv
// Bench joining the host end to the bank, checking reset tables and awkward accesses.
`timescale 1ns/1ps
module config_register_bank_bench;
	import cfg_bank_pkg::*;
	localparam int LOCK = 20; // Short lockout keeps the run brief.
	typedef struct packed {logic [7:0] ldn; logic [7:0] idx; logic [7:0] val;} row_s;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic main_por_in = 1'b1;
	logic standby_por_in = 1'b0;
	logic strap_in = 1'b0; // Low strap keeps the port where the host end expects it.
	logic req_in = 1'b0;
	logic req_write_in = 1'b0;
	logic req_data_port_in = 1'b0;
	logic [7:0] req_data_in = 8'h00;
	logic busy_out, done_out, config_mode_out, host_blocked_out;
	logic [7:0] rd_data_out, floppy_activate_out;
	int n_mismatch = 0;
	int n_tests = 0;
	int cycles = 0; // Timeout counter.
	// Device, index and reset value; the last row is an unimplemented index.
	row_s rows [0:14] = '{'{LDN_FLOPPY, IDX_PORT_LOW, 8'hF0}, '{LDN_FLOPPY, IDX_PORT_HIGH, 8'h03},
		'{LDN_FLOPPY, IDX_INDEX_ADDRESS, 8'h03}, '{LDN_FLOPPY, IDX_OSC, 8'h04},
		'{LDN_FLOPPY, IDX_REVISION, 8'h01}, '{LDN_FLOPPY, IDX_BASE_HIGH, 8'h03},
		'{LDN_FLOPPY, IDX_BASE_LOW, 8'hF0}, '{LDN_FLOPPY, IDX_IRQ, 8'h06},
		'{LDN_FLOPPY, IDX_DMA, 8'h02}, '{LDN_FLOPPY, IDX_TYPE, 8'hFF},
		'{LDN_PARPORT, IDX_MODE, 8'h3C}, '{LDN_PARPORT, IDX_DMA, 8'h04},
		'{LDN_SERIAL2, IDX_MODE_TWO, 8'h02}, '{LDN_SERIAL2, IDX_TYPE, 8'h03},
		'{LDN_SERIAL1, IDX_DMA, 8'h00}};
	cfg_bus_if bus ();
	config_register_bank #(.BLOCK_COUNT(LOCK)) u_config_register_bank (.clk_in(clk_in),
		.rst_in(rst_in), .main_por_in(main_por_in), .standby_por_in(standby_por_in),
		.strap_in(strap_in), .bus(bus), .config_mode_out(config_mode_out),
		.host_blocked_out(host_blocked_out), .floppy_activate_out(floppy_activate_out));
	config_host_end u_config_host_end (.clk_in(clk_in), .rst_in(rst_in),
		.blocked_in(host_blocked_out), .req_in(req_in), .req_write_in(req_write_in),
		.req_data_port_in(req_data_port_in), .req_data_in(req_data_in), .busy_out(busy_out),
		.done_out(done_out), .rd_data_out(rd_data_out), .bus(bus));
	config_register_bank_monitor #(.BLOCK_COUNT(LOCK)) u_monitor (.clk_in(clk_in),
		.rst_in(rst_in), .main_por_in(main_por_in), .strap_in(strap_in), .addr(bus.addr),
		.wdata(bus.wdata),
		.wr(bus.wr), .rd(bus.rd), .rvalid(bus.rvalid), .config_mode_out(config_mode_out),
		.host_blocked_out(host_blocked_out));

	// Free-running 40 MHz clock.
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	// One host request; waits a bounded time for completion, so a hang shows as a mismatch.
	task automatic cyc(input logic w, input logic dp, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		req_in <= 1'b1;
		req_write_in <= w;
		req_data_port_in <= dp;
		req_data_in <= d;
		@(posedge clk_in);
		req_in <= 1'b0;
		#1;
		chk({7'h00, busy_out}, 8'h01);
		do begin
			@(posedge clk_in);
			#1;
			n++;
		end while (done_out !== 1'b1 && n < 8);
		chk({7'h00, done_out}, 8'h01);
	endtask : cyc

	task automatic wreg(input logic [7:0] idx, input logic [7:0] val);
		cyc(1'b1, 1'b0, idx);
		cyc(1'b1, 1'b1, val);
	endtask : wreg

	task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
		cyc(1'b1, 1'b0, idx);
		cyc(1'b0, 1'b1, 8'h00);
		chk(rd_data_out, exp);
	endtask : rreg

	// Pulses one reset input for two cycles; the flag picks hard or standby reset.
	task automatic pulse(input logic hard);
		@(posedge clk_in);
		rst_in <= hard;
		standby_por_in <= !hard;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		standby_por_in <= 1'b0;
	endtask : pulse

	task automatic give_verdict;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	// Ceiling is far above the few hundred cycles the sequence needs.
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 6000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial begin
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		main_por_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk({7'h00, host_blocked_out}, 8'h01);
		while (host_blocked_out !== 1'b0 && cycles < 200) begin
			@(posedge clk_in);
			#1;
		end
		chk({7'h00, host_blocked_out}, 8'h00);
		wreg(IDX_POWER_CONTROL, 8'h77);
		chk({7'h00, config_mode_out}, 8'h00);
		cyc(1'b1, 1'b0, KEY_ENTER);
		chk({7'h00, config_mode_out}, 8'h01);
		rreg(IDX_POWER_CONTROL, 8'h00);
		foreach (rows[i]) begin
			wreg(IDX_LDN, rows[i].ldn);
			rreg(rows[i].idx, rows[i].val);
		end
		wreg(IDX_IDENTITY, 8'h00);
		rreg(IDX_IDENTITY, 8'h5A);
		wreg(8'h25, 8'hFF);
		rreg(8'h25, 8'h00);
		// Fill registers in three devices, then a soft reset must clear only some of them.
		wreg(IDX_LDN, LDN_FLOPPY);
		wreg(IDX_MODE, 8'h12);
		wreg(IDX_BASE_HIGH, 8'h11);
		wreg(IDX_ACTIVATE, 8'h01);
		@(posedge clk_in);
		#1;
		chk(floppy_activate_out, 8'h01);
		wreg(IDX_LDN, LDN_PARPORT);
		wreg(IDX_MODE, 8'h2A);
		wreg(IDX_ACTIVATE, 8'h01);
		rreg(IDX_MODE, 8'h2A);
		wreg(IDX_LDN, LDN_SERIAL2);
		wreg(IDX_MODE_TWO, 8'h09);
		wreg(IDX_CONFIG_CONTROL, 8'h01);
		rreg(IDX_LDN, 8'h00);
		rreg(IDX_MODE, 8'h12);
		rreg(IDX_BASE_HIGH, 8'h03);
		chk(floppy_activate_out, 8'h00);
		wreg(IDX_LDN, LDN_SERIAL2);
		rreg(IDX_MODE_TWO, 8'h09);
		wreg(IDX_LDN, LDN_PARPORT);
		rreg(IDX_MODE, 8'h2A);
		rreg(IDX_ACTIVATE, 8'h00);
		// Standby reset restores the parallel mode; the key is resent because the reset returns the bank to run.
		pulse(1'b0);
		cyc(1'b1, 1'b0, KEY_ENTER);
		wreg(IDX_LDN, LDN_PARPORT);
		rreg(IDX_MODE, 8'h3C);
		wreg(IDX_MODE, 8'h2A);
		wreg(IDX_TEST_FIRST, 8'h05);
		// A high strap moves the port away from where the host end writes, so the key is lost.
		@(posedge clk_in);
		strap_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		pulse(1'b1);
		cyc(1'b1, 1'b0, KEY_ENTER);
		chk({7'h00, config_mode_out}, 8'h00);
		@(posedge clk_in);
		strap_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		pulse(1'b1);
		#1;
		chk({7'h00, config_mode_out}, 8'h00);
		cyc(1'b1, 1'b0, KEY_ENTER);
		wreg(IDX_LDN, LDN_PARPORT);
		rreg(IDX_MODE, 8'h3C);
		rreg(IDX_TEST_FIRST, 8'h05);
		cyc(1'b1, 1'b0, KEY_EXIT);
		chk({7'h00, config_mode_out}, 8'h00);
		cyc(1'b0, 1'b1, 8'h00);
		chk(rd_data_out, 8'h00);
		give_verdict();
	end
endmodule : config_register_bank_bench
